// *** ieflg_top.v ***
/*
 interrupt enable and flag unit with axi4-lite register slave and return stack.
 assumes event inputs are one-cycle pulses on aclk; pins are asynchronous.
*/
// Behaviour
// - flags set on their event regardless of any enable bit.
// - global enable bit 7 passes unmasked sources to irq_request when set, blocks all of them there when clear.
// - peripheral enable bit 6 must be set for any peripheral source to reach irq_request.
// - external pin enable bit 4, flag bit 1 set on chosen edge.
// - peripheral enables at bits 7, 6, 3 and 0.
// - peripheral flags at bits 7, 6, 3 and 0, set by events, software cleared.
// - peripheral bits 5-4 and 2-1 read as zero.
// - taking an interrupt pushes the program counter before vectoring.
// - stack is eight by thirteen, circular, no overflow indication.
// - return pops top entry into program counter, upper latch untouched.
// - edge select one means rising, zero means falling edge.
// - enabled pins compare with value latched at last port read, mismatches ORed.
`timescale 1ns/1ps
`default_nettype none
`include "ieflg_regs.vh"
module ieflg_top (
   input  wire                       aclk,
   input  wire                       aresetn,
   input  wire                       ce,
   input  wire [11:0]                s_axi_awaddr,
   input  wire                       s_axi_awvalid,
   output wire                       s_axi_awready,
   input  wire [31:0]                s_axi_wdata,
   input  wire [3:0]                 s_axi_wstrb,
   input  wire                       s_axi_wvalid,
   output wire                       s_axi_wready,
   output reg  [1:0]                 s_axi_bresp,
   output reg                        s_axi_bvalid,
   input  wire                       s_axi_bready,
   input  wire [11:0]                s_axi_araddr,
   input  wire                       s_axi_arvalid,
   output wire                       s_axi_arready,
   output reg  [31:0]                s_axi_rdata,
   output reg  [1:0]                 s_axi_rresp,
   output reg                        s_axi_rvalid,
   input  wire                       s_axi_rready,
   input  wire                       timer0_ovf,
   input  wire                       timer1_ovf,
   input  wire                       eeprom_done,
   input  wire                       adc_done,
   input  wire                       comparator_change,
   input  wire                       ext_irq_pin,
   input  wire [`IEFLG_NPINS-1:0]    port_pins,
   input  wire                       port_read,
   input  wire                       irq_taken,
   input  wire                       return_from_irq,
   input  wire [`IEFLG_PCW-1:0]      pc_current,
   output wire [`IEFLG_PCW-1:0]      pc_return,
   output wire                       irq_request,
   output wire                       irq
);
   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers
   // two flops per asynchronous pin; only the second stage feeds logic,
   // ext_d only keeps the previous settled sample for the edge detector
   reg                      ext_s1;
   reg                      ext_s2;
   reg                      ext_d;
   reg [`IEFLG_NPINS-1:0]   pins_s1;
   reg [`IEFLG_NPINS-1:0]   pins_s2;
   reg [`IEFLG_NPINS-1:0]   pins_latched;
   always @(posedge aclk) begin
      if (!aresetn) begin
         ext_s1       <= 1'b0;
         ext_s2       <= 1'b0;
         ext_d        <= 1'b0;
         pins_s1      <= 6'h00;
         pins_s2      <= 6'h00;
         pins_latched <= 6'h00;
      end else if (ce) begin
         ext_s1  <= ext_irq_pin;
         ext_s2  <= ext_s1;
         ext_d   <= ext_s2;
         pins_s1 <= port_pins;
         pins_s2 <= pins_s1;
         if (port_read) begin
            pins_latched <= pins_s2;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // registers
   reg [7:0]                core;
   reg [7:0]                pflags;
   reg [7:0]                pens;
   reg [`IEFLG_NPINS-1:0]   pin_mask;
   reg [7:0]                option;
   reg [`IEFLG_NEVT-1:0]    evt_status;
   reg [`IEFLG_NEVT-1:0]    evt_mask;

   // option resets to all ones, so edges are rising until software says otherwise;
   // ext_s2 and ext_d both reset low like an idle pin, so no false edge at release
   // port change compares against the reference taken at the last port read,
   // so the flag keeps setting until software reads the port again
   wire edge_sel  = option[`IEFLG_B_EDGE];
   wire ext_edge  = edge_sel ? (ext_s2 & ~ext_d) : (~ext_s2 & ext_d);
   wire [`IEFLG_NPINS-1:0] mism = (pins_s2 ^ pins_latched) & pin_mask;
   wire port_chg  = |mism;

   // event vector: core t0, ext, port; peripheral ee, adc, cmp, t1
   wire [`IEFLG_NEVT-1:0] evt = {timer0_ovf, ext_edge, port_chg,
                                 eeprom_done, adc_done, comparator_change, timer1_ovf};

   ////////////////////////////////////////////////////////////////////////////
   // axi4-lite slave: one write and one read at a time
   // address and data may come in either order; each half is parked until
   // the other arrives, and neither is taken again while the response waits
   // only byte lane 0 holds register bits; a write without it is answered
   // but changes nothing
   reg         aw_hold;
   reg         w_hold;
   reg [11:0]  aw_addr;
   reg [31:0]  w_data;
   reg [3:0]   w_strb;
   assign s_axi_awready = ~aw_hold & ~s_axi_bvalid;
   assign s_axi_wready  = ~w_hold & ~s_axi_bvalid;
   assign s_axi_arready = ~s_axi_rvalid;

   wire [11:0] waddr = aw_hold ? aw_addr : s_axi_awaddr;
   wire [31:0] wdat  = w_hold ? w_data : s_axi_wdata;
   wire        wlane = w_hold ? w_strb[0] : s_axi_wstrb[0];
   wire        aw_ok = aw_hold | s_axi_awvalid;
   wire        w_ok  = w_hold | s_axi_wvalid;
   wire        do_wr = ce & aw_ok & w_ok & ~s_axi_bvalid;
   wire        wr_en = do_wr & wlane;
   wire        wr_core = wr_en & (waddr == `IEFLG_OFS_CORE);
   wire        wr_pfl  = wr_en & (waddr == `IEFLG_OFS_PFLAGS);
   wire        wr_sts  = wr_en & (waddr == `IEFLG_OFS_STATUS);
   wire        waddr_ok = (waddr == `IEFLG_OFS_CORE) | (waddr == `IEFLG_OFS_PFLAGS) |
                          (waddr == `IEFLG_OFS_PENS) | (waddr == `IEFLG_OFS_PINMASK) |
                          (waddr == `IEFLG_OFS_OPTION) | (waddr == `IEFLG_OFS_STATUS) |
                          (waddr == `IEFLG_OFS_MASK);

   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold      <= 1'b0;
         w_hold       <= 1'b0;
         aw_addr      <= 12'h000;
         w_data       <= 32'h00000000;
         w_strb       <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `IEFLG_RESP_OK;
      end else if (ce) begin
         if (s_axi_awvalid & s_axi_awready) begin
            aw_hold <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid & s_axi_wready) begin
            w_hold <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (do_wr) begin
            aw_hold      <= 1'b0;
            w_hold       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= waddr_ok ? `IEFLG_RESP_OK : `IEFLG_RESP_ERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // flags: event sets win over software clears
   // a write landing with an event keeps that flag set, so no event is lost
   reg [7:0] next_core;
   reg [7:0] next_pflags;
   always @* begin
      next_core = core;
      if (wr_core) begin
         next_core = wdat[7:0];
      end
      if (evt[6]) next_core[`IEFLG_B_T0_FLAG] = 1'b1;
      if (evt[5]) next_core[`IEFLG_B_EXTIF] = 1'b1;
      if (evt[4]) next_core[`IEFLG_B_PCIF]  = 1'b1;
      next_pflags = pflags;
      if (wr_pfl) begin
         next_pflags = wdat[7:0] & `IEFLG_PERI_IMPL;
      end
      if (evt[3]) next_pflags[`IEFLG_B_EE]  = 1'b1;
      if (evt[2]) next_pflags[`IEFLG_B_ADC] = 1'b1;
      if (evt[1]) next_pflags[`IEFLG_B_CMP] = 1'b1;
      if (evt[0]) next_pflags[`IEFLG_B_T1]  = 1'b1;
   end

   // sticky status behind the level output; writing a one clears a bit
   genvar gi;
   generate
      for (gi = 0; gi < `IEFLG_NEVT; gi = gi + 1) begin : g_sts
         always @(posedge aclk) begin
            if (!aresetn) begin
               evt_status[gi] <= 1'b0;
            end else if (ce) begin
               if (evt[gi]) begin
                  evt_status[gi] <= 1'b1;
               end else if (wr_sts & wdat[gi]) begin
                  evt_status[gi] <= 1'b0;
               end
            end
         end
      end
   endgenerate

   always @(posedge aclk) begin
      if (!aresetn) begin
         core     <= `IEFLG_RST_CORE;
         pflags   <= `IEFLG_RST_PERI;
         pens     <= `IEFLG_RST_PERI;
         pin_mask <= `IEFLG_RST_PIN;
         option   <= `IEFLG_RST_OPTION;
         evt_mask <= `IEFLG_RST_EVT;
      end else if (ce) begin
         core   <= next_core;
         pflags <= next_pflags;
         if (wr_en & (waddr == `IEFLG_OFS_PENS)) begin
            pens <= wdat[7:0] & `IEFLG_PERI_IMPL;
         end
         if (wr_en & (waddr == `IEFLG_OFS_PINMASK)) begin
            pin_mask <= wdat[`IEFLG_NPINS-1:0];
         end
         if (wr_en & (waddr == `IEFLG_OFS_OPTION)) begin
            option <= wdat[7:0];
         end
         if (wr_en & (waddr == `IEFLG_OFS_MASK)) begin
            evt_mask <= wdat[`IEFLG_NEVT-1:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read channel
   // data captured at acceptance, so it cannot move while rvalid waits
   reg [31:0] rd_mux;
   reg        rd_ok;
   always @* begin
      rd_ok  = 1'b1;
      rd_mux = 32'h00000000;
      case (s_axi_araddr)
         `IEFLG_OFS_CORE:    rd_mux[7:0] = core;
         `IEFLG_OFS_PFLAGS:  rd_mux[7:0] = pflags;
         `IEFLG_OFS_PENS:    rd_mux[7:0] = pens;
         `IEFLG_OFS_PINMASK: rd_mux[`IEFLG_NPINS-1:0] = pin_mask;
         `IEFLG_OFS_OPTION:  rd_mux[7:0] = option;
         `IEFLG_OFS_STATUS:  rd_mux[`IEFLG_NEVT-1:0] = evt_status;
         `IEFLG_OFS_MASK:    rd_mux[`IEFLG_NEVT-1:0] = evt_mask;
         default:            rd_ok = 1'b0;
      endcase
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h00000000;
         s_axi_rresp  <= `IEFLG_RESP_OK;
      end else if (ce) begin
         if (s_axi_arvalid & s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_mux;
            s_axi_rresp  <= rd_ok ? `IEFLG_RESP_OK : `IEFLG_RESP_ERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // request and return stack
   // request is combinational from stored bits only, no pin reaches it directly
   wire core_any = (core[`IEFLG_B_T0_EN] & core[`IEFLG_B_T0_FLAG]) |
                   (core[`IEFLG_B_EXTIE] & core[`IEFLG_B_EXTIF]) |
                   (core[`IEFLG_B_PCIE]  & core[`IEFLG_B_PCIF]);
   wire peri_any = core[`IEFLG_B_PERI_EN] & (|(pens & pflags));
   assign irq_request = core[`IEFLG_B_GLOBAL_EN] & (core_any | peri_any);
   // status and mask pair works apart from the core gating above
   assign irq = |(evt_status & evt_mask);

   // no overflow flag: deep nesting silently overwrites the oldest entry

   // push happens on the take strobe, before the core loads the vector
   ieflg_stack u_stack (
      .aclk    (aclk),
      .aresetn (aresetn),
      .ce      (ce),
      .push    (irq_taken),
      .push_pc (pc_current),
      .pop     (return_from_irq),
      .top_pc  (pc_return)
   );
endmodule
`default_nettype wire

// *** ieflg_regs.vh ***
/*
 register offsets, bit positions, reset values and widths of the interrupt enable/flag unit.
 assumes inclusion by bare name from the design files.
*/
`ifndef IEFLG_REGS_VH
`define IEFLG_REGS_VH
// register indices; each register answers at four times its index
`define IEFLG_IDX_CORE    12'h00b
`define IEFLG_IDX_PFLAGS  12'h00c
`define IEFLG_IDX_PENS    12'h08c
`define IEFLG_IDX_PINMASK 12'h096
`define IEFLG_IDX_OPTION  12'h081
// byte addresses on the axi4-lite bus
`define IEFLG_OFS_CORE    (`IEFLG_IDX_CORE << 2)
`define IEFLG_OFS_PFLAGS  (`IEFLG_IDX_PFLAGS << 2)
`define IEFLG_OFS_PENS    (`IEFLG_IDX_PENS << 2)
`define IEFLG_OFS_PINMASK (`IEFLG_IDX_PINMASK << 2)
`define IEFLG_OFS_OPTION  (`IEFLG_IDX_OPTION << 2)
`define IEFLG_OFS_STATUS  12'h100
`define IEFLG_OFS_MASK    12'h104
// core control bit positions
`define IEFLG_B_GLOBAL_EN 7
`define IEFLG_B_PERI_EN   6
`define IEFLG_B_T0_EN     5
`define IEFLG_B_EXTIE  4
`define IEFLG_B_PCIE   3
`define IEFLG_B_T0_FLAG   2
`define IEFLG_B_EXTIF  1
`define IEFLG_B_PCIF   0
// peripheral bit positions
`define IEFLG_B_EE     7
`define IEFLG_B_ADC    6
`define IEFLG_B_CMP    3
`define IEFLG_B_T1     0
`define IEFLG_PERI_IMPL 8'hc9
// option bit holding the edge select
`define IEFLG_B_EDGE   6
// reset values
`define IEFLG_RST_CORE   8'h00
`define IEFLG_RST_PERI   8'h00
`define IEFLG_RST_PIN    6'h00
`define IEFLG_RST_OPTION 8'hff
`define IEFLG_RST_EVT    7'h00
// widths
`define IEFLG_NPINS    6
`define IEFLG_NEVT     7
`define IEFLG_PCW      13
`define IEFLG_DEPTH    8
`define IEFLG_SPW      3
// axi responses
`define IEFLG_RESP_OK  2'b00
`define IEFLG_RESP_ERR 2'b10
`endif

// *** ieflg_stack.v ***
/*
 eight-entry circular return stack, thirteen bits wide.
 assumes pushes and pops come from the core on aclk; no overflow detection.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ieflg_regs.vh"
module ieflg_stack (
   input  wire                      aclk,
   input  wire                      aresetn,
   input  wire                      ce,
   input  wire                      push,
   input  wire [`IEFLG_PCW-1:0]     push_pc,
   input  wire                      pop,
   output reg  [`IEFLG_PCW-1:0]     top_pc
);
   reg [`IEFLG_PCW-1:0] mem [0:`IEFLG_DEPTH-1];
   reg [`IEFLG_SPW-1:0] sp;
   wire [`IEFLG_SPW-1:0] sp_dec = sp - 3'h1;

   // pointer simply wraps; ninth push lands on the first slot
   always @(posedge aclk) begin
      if (!aresetn) begin
         sp     <= 3'h0;
         top_pc <= 13'h0000;
      end else if (ce) begin
         if (push) begin
            mem[sp] <= push_pc;
            sp      <= sp + 3'h1;
         end else if (pop) begin
            top_pc <= mem[sp_dec];
            sp     <= sp_dec;
         end
      end
   end
endmodule
`default_nettype wire

// *** ieflg_core_model.sv ***
/*
 core side model: pushes on request when serving, pushes and pops on command.
 assumes one clock aclk and synchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module ieflg_core_model (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        irq_request,
   input  wire logic        serve,
   input  wire logic        cmd_push,
   input  wire logic        cmd_pop,
   input  wire logic [12:0] cmd_pc,
   output var  logic        irq_taken,
   output var  logic        return_from_irq,
   output var  logic [12:0] pc_current
);
   logic took;
   always @(posedge aclk) begin
      if (!aresetn) begin
         irq_taken <= 1'b0;
         return_from_irq <= 1'b0;
         pc_current <= 13'h0000;
         took <= 1'b0;
      end else begin
         // one vector per request, as a core would take it
         irq_taken <= cmd_push | (serve & irq_request & !took);
         took <= serve & (took | irq_request);
         return_from_irq <= cmd_pop;
         if (cmd_push) pc_current <= cmd_pc;
      end
   end
endmodule
`default_nettype wire

// *** ieflg_properties.sv ***
/*
 port checker for the interrupt enable/flag unit.
 assumes ce is high while the bench drives the bus and wstrb[0] is set on writes.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ieflg_regs.vh"
module ieflg_props (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic [11:0] s_axi_awaddr,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic        irq_taken,
   input wire logic        return_from_irq,
   input wire logic [12:0] pc_current,
   input wire logic [12:0] pc_return,
   input wire logic        irq_request
);
   logic [11:0] wa;
   logic [11:0] ra;
   logic [7:0]  wd;
   function automatic logic mapped(input logic [11:0] a);
      mapped = a == `IEFLG_OFS_CORE || a == `IEFLG_OFS_PFLAGS || a == `IEFLG_OFS_PENS ||
               a == `IEFLG_OFS_PINMASK || a == `IEFLG_OFS_OPTION || a == `IEFLG_OFS_STATUS ||
               a == `IEFLG_OFS_MASK;
   endfunction
   always @(posedge aclk) begin
      if (!aresetn) begin
         wa <= 12'h000;
         ra <= 12'h000;
         wd <= 8'h00;
      end else begin
         if (s_axi_awvalid && s_axi_awready) wa <= s_axi_awaddr;
         if (s_axi_wvalid && s_axi_wready) wd <= s_axi_wdata[7:0];
         if (s_axi_arvalid && s_axi_arready) ra <= s_axi_araddr;
      end
   end
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_push; irq_taken; endsequence
   sequence s_pop; return_from_irq && !irq_taken; endsequence
   ////////////////////////////////////////////////////////////////////////////
   chk_push_pop_pair: assert property (s_push ##1 s_pop |=> pc_return == $past(pc_current, 2))
      else $error("popped value differs from pushed pc");
   chk_gie_blocks: assert property ($rose(s_axi_bvalid) && wa == `IEFLG_OFS_CORE && !wd[7] |-> !irq_request)
      else $error("request with global enable clear");
   chk_peri_unimpl: assert property (s_axi_rvalid && (ra == `IEFLG_OFS_PFLAGS || ra == `IEFLG_OFS_PENS)
      |-> (s_axi_rdata & 32'hffffff36) == 32'h00000000)
      else $error("unimplemented peripheral bits read nonzero");
   chk_bresp_map: assert property ($rose(s_axi_bvalid) |-> s_axi_bresp == (mapped(wa) ? 2'b00 : 2'b10))
      else $error("write response wrong for address");
   chk_rresp_map: assert property ($rose(s_axi_rvalid) |-> s_axi_rresp == (mapped(ra) ? 2'b00 : 2'b10))
      else $error("read response wrong for address");
   chk_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   chk_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped early");
   chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   chk_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read accepted while answer pending");
endmodule
bind ieflg_top ieflg_props i_ieflg_props (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .irq_taken(irq_taken), .return_from_irq(return_from_irq), .pc_current(pc_current),
   .pc_return(pc_return), .irq_request(irq_request));
`default_nettype wire

// *** testbench.sv ***
/*
 self-checking bench for the interrupt enable/flag unit.
 assumes ieflg_top, ieflg_core_model and the register header are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ieflg_regs.vh"
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin num_errors++; \
   $display("FAIL %s exp %0h got %0h", n, e, a); end end
module testbench;
   logic aclk = 0, aresetn = 0, ce = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [11:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0;
   logic [3:0]  wstrb = 0;
   logic [4:0]  evt = 0;
   logic        ext_pin = 0, port_read = 0, serve = 0, cmd_push = 0, cmd_pop = 0, ret_d = 0;
   logic [5:0]  pins = 0;
   logic [12:0] cmd_pc = 0;
   wire  awready, wready, bvalid, arready, rvalid, irq_taken, ret, irq_request, irq;
   wire  [1:0] bresp, rresp;
   wire  [31:0] rdata;
   wire  [12:0] pc_cur, pc_ret;
   logic [33:0] exp_q[$], msk_q[$], exp_v, msk_v;
   logic [12:0] pc_q[$], p[9], pc_v;
   logic [7:0]  tbl[5] = '{8'h04, 8'h01, 8'h80, 8'h40, 8'h08};
   logic [7:0]  r;
   int num_errors = 0, checks_done = 0, cyc = 0;
   always #20 aclk = ~aclk;
   ieflg_top i_ieflg_top (.aclk(aclk), .aresetn(aresetn), .ce(ce), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .timer0_ovf(evt[0]), .timer1_ovf(evt[1]), .eeprom_done(evt[2]), .adc_done(evt[3]),
      .comparator_change(evt[4]), .ext_irq_pin(ext_pin), .port_pins(pins), .port_read(port_read),
      .irq_taken(irq_taken), .return_from_irq(ret), .pc_current(pc_cur), .pc_return(pc_ret),
      .irq_request(irq_request), .irq(irq));
   ieflg_core_model i_ieflg_core_model (.aclk(aclk), .aresetn(aresetn), .irq_request(irq_request),
      .serve(serve), .cmd_push(cmd_push), .cmd_pop(cmd_pop), .cmd_pc(cmd_pc), .irq_taken(irq_taken),
      .return_from_irq(ret), .pc_current(pc_cur));
   task conclude;
      $display("checks %0d mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] rs);
      logic [31:0] rnd;
      rnd = $urandom;
      exp_q.push_back({rs, 32'h0});
      msk_q.push_back(34'h300000000);
      @(posedge aclk);
      awaddr <= a; wdata <= {rnd[23:0], d}; wstrb <= 4'h1; awvalid <= 1; wvalid <= 1; bready <= 1;
      do begin @(posedge aclk); if (awready) awvalid <= 0; if (wready) wvalid <= 0; end while (!bvalid);
      bready <= 0;
   endtask
   task rd(input logic [11:0] a, input logic [7:0] d, input logic [1:0] rs);
      exp_q.push_back({rs, 24'h0, d});
      msk_q.push_back(rs == `IEFLG_RESP_OK ? 34'h3ffffffff : 34'h300000000);
      @(posedge aclk);
      araddr <= a; arvalid <= 1; rready <= 1;
      do begin @(posedge aclk); if (arready) arvalid <= 0; end while (!rvalid);
      rready <= 0;
   endtask
   task ev(input logic [4:0] w);
      @(posedge aclk) evt <= w;
      @(posedge aclk) evt <= 5'h00;
   endtask
   task pread;
      // let the pins pass both sync flops before the reference is latched
      repeat (3) @(posedge aclk);
      port_read <= 1;
      @(posedge aclk) port_read <= 0;
      repeat (3) @(posedge aclk);
   endtask
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 20000) begin num_errors++; conclude; end
      if ((bvalid && bready) || (rvalid && rready)) begin
         msk_v = msk_q.pop_front();
         exp_v = exp_q.pop_front();
         `CHK("axi_answer", exp_v & msk_v, (bvalid ? {bresp, 32'h0} : {rresp, rdata}) & msk_v)
      end
      if (ret_d) begin
         pc_v = pc_q.pop_front();
         `CHK("pc_return", pc_v, pc_ret)
      end
      ret_d <= ret;
   end
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(51205));
      repeat (12) @(posedge aclk);
      aresetn <= 1;
      rd(`IEFLG_OFS_CORE, 8'h00, `IEFLG_RESP_OK); rd(`IEFLG_OFS_PFLAGS, 8'h00, `IEFLG_RESP_OK);
      rd(`IEFLG_OFS_PENS, 8'h00, `IEFLG_RESP_OK); rd(12'h0f0, 8'h00, `IEFLG_RESP_ERR);
      wr(12'h0f0, 8'hff, `IEFLG_RESP_ERR);
      r = $urandom;
      wr(`IEFLG_OFS_PENS, r, `IEFLG_RESP_OK);
      rd(`IEFLG_OFS_PENS, r & 8'hc9, `IEFLG_RESP_OK);
      wr(`IEFLG_OFS_PENS, 8'h00, `IEFLG_RESP_OK);
      $display("test registers done");
      for (int i = 0; i < 5; i++) begin
         ev(5'h01 << i);
         rd(i == 0 ? `IEFLG_OFS_CORE : `IEFLG_OFS_PFLAGS, tbl[i], `IEFLG_RESP_OK);
         wr(i == 0 ? `IEFLG_OFS_CORE : `IEFLG_OFS_PFLAGS, 8'h00, `IEFLG_RESP_OK);
      end
      rd(`IEFLG_OFS_PFLAGS, 8'h00, `IEFLG_RESP_OK);
      $display("test flags done");
      for (int i = 0; i < 9; i++) begin
         p[i] = $urandom;
         @(posedge aclk) cmd_push <= 1; cmd_pc <= p[i];
      end
      @(posedge aclk) cmd_push <= 0;
      for (int i = 0; i < 8; i++) pc_q.push_back(p[8 - i]);
      repeat (2) @(posedge aclk);
      cmd_pop <= 1;
      repeat (8) @(posedge aclk);
      cmd_pop <= 0;
      repeat (4) @(posedge aclk);
      $display("test stack done");
      wr(`IEFLG_OFS_PENS, 8'h01, `IEFLG_RESP_OK);
      ev(5'h02);
      wr(`IEFLG_OFS_CORE, 8'h80, `IEFLG_RESP_OK);
      `CHK("irq_request", 1'b0, irq_request)
      wr(`IEFLG_OFS_CORE, 8'h40, `IEFLG_RESP_OK);
      `CHK("irq_request", 1'b0, irq_request)
      serve <= 1;
      pc_q.push_back(p[8]);
      wr(`IEFLG_OFS_CORE, 8'hc0, `IEFLG_RESP_OK);
      `CHK("irq_request", 1'b1, irq_request)
      serve <= 0;
      cmd_pop <= 1;
      @(posedge aclk) cmd_pop <= 0;
      wr(`IEFLG_OFS_CORE, 8'h10, `IEFLG_RESP_OK);
      wr(`IEFLG_OFS_PFLAGS, 8'h00, `IEFLG_RESP_OK);
      for (int i = 0; i < 4; i++) begin
         if (i == 2) wr(`IEFLG_OFS_OPTION, 8'hbf, `IEFLG_RESP_OK);
         @(posedge aclk) ext_pin <= ~ext_pin;
         repeat (6) @(posedge aclk);
         rd(`IEFLG_OFS_CORE, (i == 0 || i == 3) ? 8'h12 : 8'h10, `IEFLG_RESP_OK);
         wr(`IEFLG_OFS_CORE, 8'h10, `IEFLG_RESP_OK);
      end
      $display("test gating and edge done");
      wr(`IEFLG_OFS_PINMASK, 8'h04, `IEFLG_RESP_OK);
      r = $urandom;
      pins <= r[5:0];
      pread;
      wr(`IEFLG_OFS_CORE, 8'h08, `IEFLG_RESP_OK);
      @(posedge aclk) pins <= pins ^ 6'h01;
      repeat (4) @(posedge aclk);
      rd(`IEFLG_OFS_CORE, 8'h08, `IEFLG_RESP_OK);
      @(posedge aclk) pins <= pins ^ 6'h04;
      repeat (4) @(posedge aclk);
      rd(`IEFLG_OFS_CORE, 8'h09, `IEFLG_RESP_OK);
      pread;
      wr(`IEFLG_OFS_CORE, 8'h00, `IEFLG_RESP_OK);
      rd(`IEFLG_OFS_CORE, 8'h00, `IEFLG_RESP_OK);
      wr(`IEFLG_OFS_STATUS, 8'h7f, `IEFLG_RESP_OK);
      ev(5'h02);
      `CHK("irq", 1'b0, irq)
      rd(`IEFLG_OFS_STATUS, 8'h01, `IEFLG_RESP_OK);
      wr(`IEFLG_OFS_MASK, 8'h01, `IEFLG_RESP_OK);
      `CHK("irq", 1'b1, irq)
      wr(`IEFLG_OFS_STATUS, 8'h01, `IEFLG_RESP_OK);
      `CHK("irq", 1'b0, irq)
      rd(`IEFLG_OFS_MASK, 8'h01, `IEFLG_RESP_OK);
      @(posedge aclk) ce <= 0;
      ev(5'h02);
      @(posedge aclk) ce <= 1;
      rd(`IEFLG_OFS_STATUS, 8'h00, `IEFLG_RESP_OK);
      $display("test port and irq done");
      repeat (4) @(posedge aclk);
      conclude;
   end
endmodule
`default_nettype wire
